// [src/afe_pin_regs.vh]
`ifndef AFE_PIN_REGS_VH
`define AFE_PIN_REGS_VH
// ----------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------
`define R_MODE      5'h00
`define R_GAIN0     5'h01
`define R_DOFF0     5'h04
`define R_BLC       5'h07
`define R_LINE_LO   5'h08
`define R_LINE_HI   5'h09
`define R_TP_WIDTH  5'h0A
`define R_CTL_RISE0 5'h0B
`define R_CTL_FALL0 5'h15
`define R_STATUS    5'h1F
// ----------------------------------------
// Fields
// ----------------------------------------
`define MODE_LVDS      0
`define MODE_CHAN_LSB  1
`define MODE_CHAN_MSB  2
`define BLC_TGT_LSB    3
`define DOFF_MID       7'h40
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MODE      8'h06
`define RST_GAIN      8'h00
`define RST_DOFF      8'h40
`define RST_BLC       8'h40
`define RST_LINE_LO   8'hFF
`define RST_LINE_HI   8'h00
`define RST_TP_WIDTH  8'h04
`define RST_CTL       8'h00
// ----------------------------------------
// Serial frame and output timing
// ----------------------------------------
`define SER_BITS      5'd16
`define SER_HDR_BITS  5'd8
`define LVDS_SLOTS    3'd6
`define BLACK_PIXELS  16'd16
`endif

// [src/afe_pin_interface.v]
// Operation
// - Low master reset returns configuration, counters and sensor/video outputs to initial values; data registers keep theirs; pin may float high.
// - Drive sensor transfer pulse used for CCD and CIS shift control.
// - Synchronised transfer request starts a new transfer pulse.
// - Serial data uses one two-way pin, driven by device on reads.
// - Serial shift register advances on host-supplied serial clock edges.
// - Serial activity ignored unless select stays low all frame.
// - Master clock single-ended when negative input low, else differential.
// - CMOS mode puts pixel bytes on eight-bit bus shared with LVDS pairs.
// - LVDS frame clock pair sits on bus bits 7 and 6.
// - LVDS lanes 2,1,0 sit on bits 5:4, 3:2, 1:0.
// - Strobe qualifies CMOS data; in LVDS it is another control output.
// - Nine configurable sensor control outputs with programmed waveforms.
// - One 16-bit converter shared among channels.
// - Channel count one to three sets per-channel sample rate.
// - Independent gain and offset per input.
// - Gain code is eight bits, 256 steps.
// - Each channel has its own black level loop, separately enabled.
// - Digital offset spans -1024 to +1008 LSB in 16 LSB steps.
`timescale 1ns/1ps
`default_nettype none
`include "afe_pin_regs.vh"
module afe_pin_interface (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        master_reset_n,
	input  wire        transfer_pulse_request,
	input  wire        serial_clock,
	input  wire        serial_select_n,
	input  wire        serial_data_in,
	output reg         serial_data_out,
	output reg         serial_data_oe,
	input  wire        master_clock_in_pos,
	input  wire        master_clock_in_neg,
	input  wire [15:0] adc_sample,
	output reg  [1:0]  adc_channel,
	output wire [23:0] pga_gain,
	output reg  [7:0]  video_bus,
	output reg         cmos_pixel_strobe,
	output reg         sensor_transfer_pulse,
	output reg  [8:0]  sensor_ctl
);
// ----------------------------------------
// Input synchronisers
// ----------------------------------------
	reg [1:0] s_rst;
	reg [2:0] s_req;
	reg [2:0] s_sck;
	reg [1:0] s_sen;
	reg [1:0] s_sdi;
	reg [2:0] s_mclk;
	reg [2:0] s_mneg;
	wire      mclk_now;
	wire      mclk_old;
	wire      run;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_rst  <= 2'b00;
			s_req  <= 3'b000;
			s_sck  <= 3'b000;
			s_sen  <= 2'b11;
			s_sdi  <= 2'b00;
			s_mclk <= 3'b000;
			s_mneg <= 3'b000;
		end else begin
			s_rst  <= {s_rst[0], master_reset_n};
			s_req  <= {s_req[1:0], transfer_pulse_request};
			s_sck  <= {s_sck[1:0], serial_clock};
			s_sen  <= {s_sen[0], serial_select_n};
			s_sdi  <= {s_sdi[0], serial_data_in};
			s_mclk <= {s_mclk[1:0], master_clock_in_pos};
			s_mneg <= {s_mneg[1:0], master_clock_in_neg};
		end
	end
	assign run = s_rst[1];
	// Clock pins synchronised apart, combined only after
	assign mclk_now = s_mclk[1] & ~s_mneg[1];
	assign mclk_old = s_mclk[2] & ~s_mneg[2];
	wire sck_rise = s_sck[1] & ~s_sck[2];
	wire sck_fall = ~s_sck[1] & s_sck[2];
	wire req_rise = s_req[1] & ~s_req[2];
	wire tick     = mclk_now & ~mclk_old;
// ----------------------------------------
// Configuration registers
// ----------------------------------------
	reg  [7:0]  cfg [0:30];
	reg         a_wr_q;
	reg  [4:0]  a_idx_q;
	reg         a_ok_q;
	wire [4:0]  a_idx = haddr[6:2];
	wire        a_ok  = (haddr[31:7] == 25'h0000000) && (a_idx != `R_STATUS);
	wire        a_go  = hsel & hready & htrans[1];
	reg         s_wr;
	reg  [4:0]  s_wadr;
	reg  [7:0]  s_wdat;
	wire [7:0]  status;
	integer     i;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr_q  <= 1'b0;
			a_idx_q <= 5'h00;
			a_ok_q  <= 1'b0;
			hrdata  <= 32'h00000000;
		end else begin
			a_wr_q  <= a_go & hwrite;
			a_idx_q <= a_idx;
			a_ok_q  <= a_ok;
			if (a_go && !hwrite) begin
				if (haddr[31:7] != 25'h0000000)
					hrdata <= 32'h00000000;
				else if (a_idx == `R_STATUS)
					hrdata <= {24'h000000, status};
				else
					hrdata <= {24'h000000, cfg[a_idx]};
			end
		end
	end
	// Bus write wins over a serial write in the same cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (i = 0; i < 31; i = i + 1)
				cfg[i] <= `RST_CTL;
			cfg[`R_MODE]     <= `RST_MODE;
			cfg[`R_GAIN0]    <= `RST_GAIN;
			cfg[`R_GAIN0+1]  <= `RST_GAIN;
			cfg[`R_GAIN0+2]  <= `RST_GAIN;
			cfg[`R_DOFF0]    <= `RST_DOFF;
			cfg[`R_DOFF0+1]  <= `RST_DOFF;
			cfg[`R_DOFF0+2]  <= `RST_DOFF;
			cfg[`R_BLC]      <= `RST_BLC;
			cfg[`R_LINE_LO]  <= `RST_LINE_LO;
			cfg[`R_LINE_HI]  <= `RST_LINE_HI;
			cfg[`R_TP_WIDTH] <= `RST_TP_WIDTH;
		end else if (!run) begin
			for (i = 0; i < 31; i = i + 1)
				cfg[i] <= `RST_CTL;
			cfg[`R_MODE]     <= `RST_MODE;
			cfg[`R_DOFF0]    <= `RST_DOFF;
			cfg[`R_DOFF0+1]  <= `RST_DOFF;
			cfg[`R_DOFF0+2]  <= `RST_DOFF;
			cfg[`R_BLC]      <= `RST_BLC;
			cfg[`R_LINE_LO]  <= `RST_LINE_LO;
			cfg[`R_TP_WIDTH] <= `RST_TP_WIDTH;
		end else if (a_wr_q && a_ok_q) begin
			cfg[a_idx_q] <= hwdata[7:0];
		end else if (s_wr && s_wadr != `R_STATUS) begin
			cfg[s_wadr] <= s_wdat;
		end
	end
	wire       lvds   = cfg[`R_MODE][`MODE_LVDS];
	wire [1:0] nchan  = cfg[`R_MODE][`MODE_CHAN_MSB:`MODE_CHAN_LSB];
	wire [15:0] line_len = {cfg[`R_LINE_HI], cfg[`R_LINE_LO]};
	assign pga_gain = {cfg[`R_GAIN0+2], cfg[`R_GAIN0+1], cfg[`R_GAIN0]};
// ----------------------------------------
// Serial port
// ----------------------------------------
	reg [4:0]  sp_cnt;
	reg [15:0] sp_sh;
	reg        sp_rd;
	reg [7:0]  sp_out;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_cnt          <= 5'd0;
			sp_sh           <= 16'h0000;
			sp_rd           <= 1'b0;
			sp_out          <= 8'h00;
			s_wr            <= 1'b0;
			s_wadr          <= 5'h00;
			s_wdat          <= 8'h00;
			serial_data_out <= 1'b0;
			serial_data_oe  <= 1'b0;
		end else begin
			s_wr <= 1'b0;
			if (!run || s_sen[1]) begin
				sp_cnt         <= 5'd0;
				sp_rd          <= 1'b0;
				serial_data_oe <= 1'b0;
			end else if (sck_rise && sp_cnt != `SER_BITS) begin
				sp_sh  <= {sp_sh[14:0], s_sdi[1]};
				sp_cnt <= sp_cnt + 5'd1;
				// Read data fetched once the address is in
				if (sp_cnt == `SER_HDR_BITS - 5'd1) begin
					sp_rd  <= sp_sh[6];
					sp_out <= (sp_sh[5:4] == 2'b00 && {sp_sh[3:0], s_sdi[1]} != `R_STATUS)
						? cfg[{sp_sh[3:0], s_sdi[1]}]
						: ({sp_sh[3:0], s_sdi[1]} == `R_STATUS ? status : 8'h00);
				end
				if (sp_cnt == `SER_BITS - 5'd1 && !sp_sh[14] && sp_sh[13:12] == 2'b00) begin
					s_wr   <= 1'b1;
					s_wadr <= sp_sh[11:7];
					s_wdat <= {sp_sh[6:0], s_sdi[1]};
				end
			end else if (sck_fall && sp_rd && sp_cnt != `SER_BITS) begin
				serial_data_oe  <= 1'b1;
				serial_data_out <= sp_out[7];
				sp_out          <= {sp_out[6:0], 1'b0};
			end else if (sck_fall && sp_cnt == `SER_BITS) begin
				serial_data_oe <= 1'b0;
			end
		end
	end
// ----------------------------------------
// Line timing and sensor outputs
// ----------------------------------------
	reg  [15:0] pix_q;
	reg  [7:0]  tp_q;
	wire [9:0]  ctl_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pix_q                 <= 16'h0000;
			tp_q                  <= 8'h00;
			sensor_transfer_pulse <= 1'b0;
		end else if (!run) begin
			pix_q                 <= 16'h0000;
			tp_q                  <= 8'h00;
			sensor_transfer_pulse <= 1'b0;
		end else begin
			if (req_rise || (tick && pix_q >= line_len)) begin
				pix_q                 <= 16'h0000;
				tp_q                  <= cfg[`R_TP_WIDTH];
				sensor_transfer_pulse <= (cfg[`R_TP_WIDTH] != 8'h00);
			end else if (tick) begin
				pix_q <= pix_q + 16'd1;
				if (tp_q != 8'h00)
					tp_q <= tp_q - 8'd1;
				sensor_transfer_pulse <= (tp_q > 8'd1);
			end
		end
	end
	genvar g;
	generate
		for (g = 0; g < 10; g = g + 1) begin : ctl_gen
			reg bit_q;
			assign ctl_q[g] = bit_q;
			// Fall checked first: equal counts keep the output low
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					bit_q <= 1'b0;
				else if (!run)
					bit_q <= 1'b0;
				else if (pix_q[15:8] != 8'h00 || pix_q[7:0] == cfg[`R_CTL_FALL0+g])
					bit_q <= 1'b0;
				else if (pix_q[7:0] == cfg[`R_CTL_RISE0+g])
					bit_q <= 1'b1;
			end
		end
	endgenerate
	always @* begin
		sensor_ctl = ctl_q[8:0];
	end
// ----------------------------------------
// Sample path: offset and black level
// ----------------------------------------
	reg  [1:0]  ch_q;
	reg  [15:0] pix_data_q;
	reg         pix_new_q;
	reg  signed [11:0] blc_q [0:2];
	wire [6:0]  doff = cfg[`R_DOFF0+ch_q][6:0];
	wire signed [17:0] doff_lsb = $signed({1'b0, doff, 4'h0}) - 18'sd1024;
	wire signed [17:0] sum = $signed({2'b00, adc_sample}) + doff_lsb
		+ {{6{blc_q[ch_q][11]}}, blc_q[ch_q]};
	wire [15:0] sat = sum[17] ? 16'h0000 : (sum[16] ? 16'hFFFF : sum[15:0]);
	wire [15:0] blc_tgt = {8'h00, cfg[`R_BLC][7:`BLC_TGT_LSB], 3'b000};
	wire        black = pix_q < `BLACK_PIXELS;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch_q        <= 2'd0;
			adc_channel <= 2'd0;
			pix_data_q  <= 16'h0000;
			pix_new_q   <= 1'b0;
			blc_q[0]    <= 12'sd0;
			blc_q[1]    <= 12'sd0;
			blc_q[2]    <= 12'sd0;
		end else if (!run) begin
			ch_q        <= 2'd0;
			adc_channel <= 2'd0;
			pix_new_q   <= 1'b0;
			blc_q[0]    <= 12'sd0;
			blc_q[1]    <= 12'sd0;
			blc_q[2]    <= 12'sd0;
		end else begin
			pix_new_q <= tick;
			if (tick) begin
				pix_data_q <= sat;
				if (cfg[`R_BLC][ch_q] && black) begin
					if (sat > blc_tgt && blc_q[ch_q] != 12'sh800)
						blc_q[ch_q] <= blc_q[ch_q] - 12'sd1;
					else if (sat < blc_tgt && blc_q[ch_q] != 12'sh7FF)
						blc_q[ch_q] <= blc_q[ch_q] + 12'sd1;
				end
				if (ch_q + 2'd1 >= nchan || nchan == 2'd0) begin
					ch_q        <= 2'd0;
					adc_channel <= 2'd0;
				end else begin
					ch_q        <= ch_q + 2'd1;
					adc_channel <= ch_q + 2'd1;
				end
			end
		end
	end
	assign status = {3'b000, s_sen[1], sensor_transfer_pulse, lvds, ch_q};
// ----------------------------------------
// Output formatter
// ----------------------------------------
	reg [15:0] out_sh;
	reg [2:0]  slot;
	reg        busy;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_sh            <= 16'h0000;
			slot              <= 3'd0;
			busy              <= 1'b0;
			video_bus         <= 8'h00;
			cmos_pixel_strobe <= 1'b0;
		end else if (!run) begin
			busy              <= 1'b0;
			slot              <= 3'd0;
			video_bus         <= 8'h00;
			cmos_pixel_strobe <= 1'b0;
		end else if (pix_new_q) begin
			out_sh <= pix_data_q;
			slot   <= 3'd0;
			busy   <= 1'b1;
			if (!lvds) begin
				video_bus         <= pix_data_q[15:8];
				cmos_pixel_strobe <= 1'b0;
			end else begin
				cmos_pixel_strobe <= ctl_q[9];
			end
		end else if (busy && !lvds) begin
			slot <= slot + 3'd1;
			cmos_pixel_strobe <= ~slot[0];
			if (slot == 3'd1)
				video_bus <= out_sh[7:0];
			if (slot == 3'd3)
				busy <= 1'b0;
		end else if (busy && lvds) begin
			cmos_pixel_strobe <= ctl_q[9];
			video_bus[7] <= (slot < 3'd3);
			video_bus[6] <= ~(slot < 3'd3);
			video_bus[5] <= out_sh[15];
			video_bus[4] <= ~out_sh[15];
			video_bus[3] <= out_sh[14];
			video_bus[2] <= ~out_sh[14];
			video_bus[1] <= out_sh[13];
			video_bus[0] <= ~out_sh[13];
			out_sh <= {out_sh[12:0], 3'b000};
			slot   <= slot + 3'd1;
			if (slot == `LVDS_SLOTS - 3'd1)
				busy <= 1'b0;
		end else begin
			cmos_pixel_strobe <= lvds ? ctl_q[9] : 1'b0;
		end
	end
endmodule
`default_nettype wire

// [test/afe_pin_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module afe_pin_asserts (
	input wire        hclk,
	input wire        hresetn,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	input wire        master_reset_n,
	input wire        transfer_pulse_request,
	input wire        serial_select_n,
	input wire        serial_data_oe,
	input wire [1:0]  adc_channel,
	input wire [7:0]  video_bus,
	input wire        cmos_pixel_strobe,
	input wire        sensor_transfer_pulse,
	input wire [8:0]  sensor_ctl
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_oe_idle: assert property (serial_select_n [*4] |-> !serial_data_oe)
		else $error("serial pin driven while deselected");
	a_mreset_quiet: assert property (!master_reset_n [*4] |-> !sensor_transfer_pulse
		&& sensor_ctl == 9'h000 && video_bus == 8'h00 && !cmos_pixel_strobe)
		else $error("outputs active in master reset");
	a_tp_request: assert property ($rose(transfer_pulse_request) && master_reset_n
		|-> ##[1:8] sensor_transfer_pulse)
		else $error("no transfer pulse after request");
	a_chan_legal: assert property (adc_channel != 2'h3)
		else $error("channel out of range");
	a_strobe_single: assert property ($rose(cmos_pixel_strobe) |=> !cmos_pixel_strobe)
		else $error("strobe longer than one cycle");
	a_byte_held: assert property (cmos_pixel_strobe |-> $stable(video_bus))
		else $error("byte moved under strobe");
endmodule
bind afe_pin_interface afe_pin_asserts u_afe_pin_asserts (.hclk, .hresetn, .hreadyout, .hresp,
	.hrdata, .master_reset_n, .transfer_pulse_request, .serial_select_n, .serial_data_oe,
	.adc_channel, .video_bus, .cmos_pixel_strobe, .sensor_transfer_pulse, .sensor_ctl);
`default_nettype wire

// [test/pixel_receiver.sv]
`timescale 1ns/1ps
`default_nettype none
module pixel_receiver (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [7:0]  video_bus,
	input wire logic        cmos_pixel_strobe,
	output logic     [15:0] word_q,
	output logic     [7:0]  bytes_q
);
	// Bytes taken on strobe, high byte first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_q <= 16'h0000;
			bytes_q <= 8'h00;
		end else if (cmos_pixel_strobe) begin
			word_q <= {word_q[7:0], video_bus};
			bytes_q <= bytes_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

// [test/afe_digital_pin_interface_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "afe_pin_regs.vh"
module afe_digital_pin_interface_bench;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        master_reset_n = 1'b1, transfer_pulse_request = 1'b0;
	logic        serial_clock = 1'b0, serial_select_n = 1'b1, host_bit = 1'b0;
	logic        clk_pos = 1'b0, clk_neg = 1'b0;
	logic [15:0] adc_sample = 16'h0;
	wire         hreadyout, hresp, serial_data_out, serial_data_oe;
	wire         cmos_pixel_strobe, sensor_transfer_pulse;
	wire [31:0]  hrdata;
	wire [1:0]   adc_channel;
	wire [23:0]  pga_gain;
	wire [7:0]   video_bus, bytes_q;
	wire [8:0]   sensor_ctl;
	wire [15:0]  word_q;
	wire         sdio = serial_data_oe ? serial_data_out : host_bit;
	int          fail_count = 0, tests_run = 0, cycles = 0;
	logic [5:0]  idx_t [6] = '{6'h00, 6'h04, 6'h07, 6'h08, 6'h0A, 6'h20};
	logic [7:0]  val_t [6] = '{8'h06, 8'h40, 8'h40, 8'hFF, 8'h04, 8'h00};
	logic [7:0]  doff_t [3] = '{8'h41, 8'h7F, 8'h00};
	logic [15:0] in_t [3] = '{16'h1234, 16'hFFF0, 16'h1234};
	logic [15:0] exp_t [3] = '{16'h1244, 16'hFFFF, 16'h0E34};

	always #50 hclk = ~hclk;

	afe_pin_interface u_afe_pin_interface (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .master_reset_n,
		.transfer_pulse_request, .serial_clock, .serial_select_n, .serial_data_in(sdio),
		.serial_data_out, .serial_data_oe, .master_clock_in_pos(clk_pos),
		.master_clock_in_neg(clk_neg), .adc_sample, .adc_channel, .pga_gain, .video_bus,
		.cmos_pixel_strobe, .sensor_transfer_pulse, .sensor_ctl);
	pixel_receiver u_pixel_receiver (.hclk, .hresetn, .video_bus, .cmos_pixel_strobe,
		.word_q, .bytes_q);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task conclude;
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task ahb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, idx, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge hclk);
	endtask
	task ser(input logic [15:0] f, input int n);
		rd = 32'h0;
		serial_select_n <= 1'b0;
		repeat (4) @(posedge hclk);
		for (int i = 15; i > 15 - n; i--) begin
			host_bit <= f[i];
			repeat (4) @(posedge hclk);
			serial_clock <= 1'b1;
			repeat (4) @(posedge hclk);
			if (i < 8)
				rd[i] = sdio;
			serial_clock <= 1'b0;
		end
		repeat (4) @(posedge hclk);
		serial_select_n <= 1'b1;
		repeat (8) @(posedge hclk);
	endtask
	// Differential clock in LVDS, negative input grounded otherwise
	task tick(input logic [15:0] s, input logic lvds);
		adc_sample <= s;
		clk_pos <= 1'b1;
		clk_neg <= 1'b0;
		repeat (4) @(posedge hclk);
		clk_pos <= 1'b0;
		clk_neg <= lvds;
		repeat (4) @(posedge hclk);
	endtask

	always @(posedge hclk) begin
		cycles++;
		if (cycles > 20000) begin
			fail_count++;
			conclude();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		for (int j = 0; j < 6; j++) begin
			ahb(1'b0, idx_t[j], 8'h00);
			chk(rd, {24'h0, val_t[j]});
		end
		ahb(1'b1, {1'b0, `R_GAIN0}, 8'h12);
		ahb(1'b1, {1'b0, `R_GAIN0 + 5'h02}, 8'hAB);
		chk({8'h0, pga_gain}, 32'hAB0012);
		ser({1'b0, 7'h02, 8'h55}, 16);
		chk({8'h0, pga_gain}, 32'hAB5512);
		ser({1'b0, 7'h02, 8'h77}, 12);
		ahb(1'b0, 6'h02, 8'h00);
		chk(rd, 32'h55);
		ser({1'b1, 7'h03, 8'h00}, 16);
		chk({24'h0, rd[7:0]}, 32'hAB);
		ahb(1'b1, {1'b0, `R_MODE}, 8'h02);
		for (int j = 0; j < 3; j++) begin
			ahb(1'b1, {1'b0, `R_DOFF0}, doff_t[j]);
			tick(in_t[j], 1'b0);
			for (int k = 0; k < 20 && bytes_q !== 8'(2 * j + 2); k++) @(posedge hclk);
			chk({16'h0, word_q}, {16'h0, exp_t[j]});
		end
		transfer_pulse_request <= 1'b1;
		for (int k = 0; k < 10 && sensor_transfer_pulse !== 1'b1; k++) @(posedge hclk);
		chk({31'h0, sensor_transfer_pulse}, 32'h1);
		transfer_pulse_request <= 1'b0;
		ahb(1'b1, {1'b0, `R_MODE}, 8'h03);
		fork
			tick(16'hA400, 1'b1);
			begin
				for (int k = 0; k < 20 && video_bus[7] !== 1'b1; k++) @(posedge hclk);
				chk({24'h0, video_bus}, 32'hA6);
			end
		join
		master_reset_n <= 1'b0;
		repeat (6) @(posedge hclk);
		master_reset_n <= 1'b1;
		repeat (4) @(posedge hclk);
		ahb(1'b0, {1'b0, `R_MODE}, 8'h00);
		chk(rd, 32'h06);
		ahb(1'b1, {1'b0, `R_CTL_RISE0}, 8'h01);
		ahb(1'b1, {1'b0, `R_CTL_FALL0}, 8'h02);
		tick(16'h0050, 1'b0);
		chk({23'h0, sensor_ctl}, 32'h001);
		chk({30'h0, adc_channel}, 32'h1);
		ahb(1'b1, {1'b0, `R_MODE}, 8'h02);
		ahb(1'b1, {1'b0, `R_BLC}, 8'h41);
		tick(16'h0050, 1'b0);
		chk({23'h0, sensor_ctl}, 32'h000);
		repeat (2) tick(16'h0050, 1'b0);
		repeat (4) @(posedge hclk);
		chk({16'h0, word_q}, 32'h004F);
		conclude();
	end
endmodule
`default_nettype wire
